// ### logic/mbs_pkg.sv
// Shared constants for the Modbus slave front end and its network setup.
// Assumes one 25 MHz core clock; all users import this package.
package mbs_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 16;
   localparam int IP_W = 32;
   localparam int SW_W = 4;

   // ****************************************
   // Function and exception codes
   // ****************************************
   localparam logic [BYTE_W-1:0] FC_READ = 8'h03;
   localparam logic [BYTE_W-1:0] FC_WRITE_ONE = 8'h06;
   localparam logic [BYTE_W-1:0] FC_WRITE_MANY = 8'h10;
   localparam logic [BYTE_W-1:0] EXC_FLAG = 8'h80;
   localparam logic [BYTE_W-1:0] EXC_NONE = 8'h00;
   localparam logic [BYTE_W-1:0] EXC_FUNC = 8'h01;
   localparam logic [BYTE_W-1:0] EXC_ADDR = 8'h02;
   localparam logic [BYTE_W-1:0] EXC_VALUE = 8'h03;
   localparam logic [BYTE_W-1:0] EXC_FAIL = 8'h04;
   localparam logic [WORD_W-1:0] MAX_READ = 16'h007d;
   localparam logic [WORD_W-1:0] MAX_WRITE = 16'h007b;
   localparam logic [WORD_W-1:0] ONE_WORD = 16'h0001;
   localparam logic [ADDR_W:0] ADDR_SPAN = 17'h10000;

   // ****************************************
   // Holding register map
   // ****************************************
   localparam int REG_DEPTH = 16;
   localparam int REG_AW = 4;
   localparam logic [REG_DEPTH-1:0] REG_READABLE = 16'hfffe;
   localparam logic [REG_DEPTH-1:0] REG_WRITABLE = 16'hffef;
   localparam logic [REG_DEPTH-1:0] REG_CONT = 16'h0080;
   localparam logic [REG_DEPTH-1:0] REG_BYTE_WIDE = 16'h0022;
   localparam logic [WORD_W-1:0] LIMIT_BYTE = 16'h00ff;
   localparam logic [WORD_W-1:0] LIMIT_WORD = 16'hffff;

   // ****************************************
   // Network address setup
   // ****************************************
   localparam logic [SW_W-1:0] MODE_SOFTWARE_CONFIG = 4'h0;
   localparam logic [SW_W-1:0] MODE_BOOTP = 4'h1;
   localparam logic [SW_W-1:0] MODE_FIXED = 4'h2;
   localparam logic [SW_W-1:0] MODE_RESTORE = 4'h3;
   localparam logic [1:0] SRC_DHCP = 2'h0;
   localparam logic [1:0] SRC_BOOTP = 2'h1;
   localparam logic [1:0] SRC_FIXED = 2'h2;
   localparam logic [IP_W-1:0] DEFAULT_RANGE = 32'hc0a81464;
   localparam logic [IP_W-1:0] NO_ADDRESS = 32'h00000000;
   localparam logic [BYTE_W-1:0] CFG_PROCESS = 8'h7d;
   localparam logic [BYTE_W-1:0] PAR_HOST = 8'h0e;
   localparam logic [BYTE_W-1:0] PAR_MASK = 8'h0f;
   localparam logic [BYTE_W-1:0] PAR_ROUTER = 8'h10;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int RESP_TIME_MS = 100;
   localparam int RESP_CYCLES = (CLK_HZ / 1000) * RESP_TIME_MS;
   localparam int RESP_GUARD = 4;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_SCAN = 5'h02,
      S_WRITE = 5'h04,
      S_RESP = 5'h08,
      S_STREAM = 5'h10
   } fsm_state_type;

endpackage

// ### logic/holding_mem.sv
// Small holding register store with one write port and a registered read.
// Assumes the caller keeps addresses below DEPTH.
module holding_mem #(
   parameter int DEPTH = mbs_pkg::REG_DEPTH,
   parameter int AW = mbs_pkg::REG_AW,
   parameter int DW = mbs_pkg::WORD_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   // Read port
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);
   import mbs_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } mem_state_type;

   mem_state_type q;
   mem_state_type d;

   // Read during write returns the old word
   always_comb begin
      d = q;
      if (wrEn) begin
         d.mem[wrAddr] = wrData;
      end
      d.rd = q.mem[rdAddr];
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdData = q.rd;
endmodule

// ### logic/reg_attr.sv
// Attribute lookup for one holding register address.
// Assumes the map in the package; pure combinational logic.
module reg_attr (
   // Register address, one bit wider to flag the end of the space
   input wire logic [mbs_pkg::ADDR_W:0] addr,
   // Attributes
   output logic exists,
   output logic readable,
   output logic writable,
   output logic cont,
   output logic [mbs_pkg::WORD_W-1:0] limit
);
   import mbs_pkg::*;

   logic [REG_AW-1:0] index;

   always_comb begin
      index = addr[REG_AW-1:0];
      exists = (addr < (ADDR_W+1)'(REG_DEPTH));
      readable = exists && REG_READABLE[index];
      writable = exists && REG_WRITABLE[index];
      cont = exists && REG_CONT[index];
      limit = REG_BYTE_WIDE[index] ? LIMIT_BYTE : LIMIT_WORD;
   end
endmodule

// ### logic/modbus_slave_netconfig.sv
// Modbus slave request handler plus network address source selection.
// Assumes requests arrive parsed, switches are synchronous, one core clock.
//
// Summary of operation
// - With no other source configured, obtain the address by DHCP.
// - Fixed switch setting: default range 192.168.20.x, last byte from switches.
// - Boot protocol switch setting: obtain the address by BOOTP.
// - Restore setting at power-up erases stored addresses, every power-up.
// - Mode and low-byte switches are sampled only at power-up.
// - Low-byte switches apply in fixed mode, and when nonzero to a written host address.
// - Host address reads 0.0.0.0 when unset; writing an address selects fixed.
// - Nonzero switches give last byte; writing zero restores DHCP only if switches zero.
// - Host, mask, router addresses sit at process 125, parameters 14 to 16.
// - Written network settings apply only after power-up or soft restart.
// - Every valid request is answered within 100 ms.
// - Accept read holding, write single and write multiple registers.
// - Read of missing register or partial multi-register parameter gives exception 02.
// - Read count below 1 or above 125 gives exception 03.
// - Read covering a write-only register gives exception 04.
// - Write to missing register or partial parameter gives exception 02.
// - Write to a read-only register gives exception 04.
// - Write of a value not allowed gives exception 04.
// - Write multiple count below 1 or above 123 gives exception 03.
// - After one write exception, all following values are discarded.
// - Register number minus one is the request address, 0 to 65535.
module modbus_slave_netconfig
   import mbs_pkg::*;
#(
   parameter int RESP_CYC = mbs_pkg::RESP_CYCLES,
   parameter logic [mbs_pkg::IP_W-1:0] FACTORY_HOST = 32'h00000000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Request
   input wire logic reqValid,
   input wire logic [mbs_pkg::BYTE_W-1:0] reqFunc,
   input wire logic [mbs_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [mbs_pkg::WORD_W-1:0] reqCount,
   input wire logic [mbs_pkg::WORD_W-1:0] reqValue,
   output logic reqReady,
   // Write multiple data words
   input wire logic wrValid,
   input wire logic [mbs_pkg::WORD_W-1:0] wrData,
   output logic wrReady,
   // Answer header
   output logic respValid,
   output logic [mbs_pkg::BYTE_W-1:0] respFunc,
   output logic [mbs_pkg::BYTE_W-1:0] respExc,
   output logic [mbs_pkg::ADDR_W-1:0] respAddr,
   output logic [mbs_pkg::WORD_W-1:0] respQty,
   // Answer read data
   output logic rdValid,
   output logic [mbs_pkg::WORD_W-1:0] rdData,
   output logic rdLast,
   // Switches and restart
   input wire logic [mbs_pkg::SW_W-1:0] modeSwitch,
   input wire logic [mbs_pkg::BYTE_W-1:0] lowByteSwitch,
   input wire logic softRestart,
   // Configuration parameter access
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [mbs_pkg::BYTE_W-1:0] cfgProcess,
   input wire logic [mbs_pkg::BYTE_W-1:0] cfgParam,
   input wire logic [mbs_pkg::IP_W-1:0] cfgData,
   output logic [mbs_pkg::IP_W-1:0] cfgRdData,
   // Applied network settings
   output logic [mbs_pkg::IP_W-1:0] networkHostAddress,
   output logic [mbs_pkg::IP_W-1:0] networkMaskSetting,
   output logic [mbs_pkg::IP_W-1:0] networkRouterAddress,
   output logic [1:0] addrSource
);
   import mbs_pkg::*;

   localparam int LAT_W = $clog2(RESP_CYC + 1);

   typedef struct packed {
      fsm_state_type st;
      logic rdy;
      logic [BYTE_W-1:0] func;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] cnt;
      logic [WORD_W-1:0] val;
      logic [ADDR_W:0] idx;
      logic [WORD_W-1:0] left;
      logic [BYTE_W-1:0] exc;
      logic [LAT_W-1:0] lat;
      logic respV;
      logic [BYTE_W-1:0] respF;
      logic [BYTE_W-1:0] respE;
      logic [ADDR_W-1:0] respA;
      logic [WORD_W-1:0] respQ;
      logic wrRdy;
      logic pend;
      logic pendLast;
      logic rdV;
      logic rdL;
      logic [WORD_W-1:0] rdD;
      logic memWr;
      logic [REG_AW-1:0] memWa;
      logic [WORD_W-1:0] memWd;
      logic sampled;
      logic applyPend;
      logic [SW_W-1:0] mode;
      logic [BYTE_W-1:0] lsb;
      logic [IP_W-1:0] sHost;
      logic [IP_W-1:0] sMask;
      logic [IP_W-1:0] sRouter;
      logic sFixed;
      logic [IP_W-1:0] aHost;
      logic [IP_W-1:0] aMask;
      logic [IP_W-1:0] aRouter;
      logic [1:0] src;
      logic [IP_W-1:0] cfgRd;
   } top_state_type;

   top_state_type q;
   top_state_type d;

   logic aExists;
   logic aRead;
   logic aWrite;
   logic aCont;
   logic [WORD_W-1:0] aLimit;
   logic [WORD_W-1:0] memRd;

   // ****************************************
   // Register map and store
   // ****************************************
   reg_attr attr (
      .addr(q.idx),
      .exists(aExists),
      .readable(aRead),
      .writable(aWrite),
      .cont(aCont),
      .limit(aLimit)
   );

   holding_mem #(
      .DEPTH(REG_DEPTH),
      .AW(REG_AW),
      .DW(WORD_W)
   ) store (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .wrEn(q.memWr),
      .wrAddr(q.memWa),
      .wrData(q.memWd),
      .rdAddr(q.idx[REG_AW-1:0]),
      .rdData(memRd)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [ADDR_W:0] reqEnd;
      logic [ADDR_W:0] qEnd;
      logic [WORD_W-1:0] reqCnt;
      logic single;
      logic [WORD_W-1:0] word;
      logic wordV;
      reqCnt = (reqFunc == FC_WRITE_ONE) ? ONE_WORD : reqCount;
      reqEnd = {1'b0, reqAddr} + {1'b0, reqCnt};
      qEnd = {1'b0, q.addr} + {1'b0, q.cnt};
      single = (q.func == FC_WRITE_ONE);
      word = single ? q.val : wrData;
      wordV = single || (wrValid && q.wrRdy);
      d = q;
      d.respV = 1'b0;
      d.rdV = 1'b0;
      d.rdL = 1'b0;
      d.memWr = 1'b0;
      d.pend = 1'b0;

      // Switches are caught once, on the first clock after reset
      if (!q.sampled) begin
         d.sampled = 1'b1;
         d.mode = modeSwitch;
         d.lsb = lowByteSwitch;
         d.applyPend = 1'b1;
         if (modeSwitch == MODE_RESTORE) begin
            d.sHost = NO_ADDRESS;
            d.sMask = NO_ADDRESS;
            d.sRouter = NO_ADDRESS;
            d.sFixed = 1'b0;
         end
      end else if (cfgWrite && cfgProcess == CFG_PROCESS) begin
         // Stored only; the live address changes at the next apply
         if (cfgParam == PAR_HOST) begin
            d.sHost = cfgData;
            if (cfgData != NO_ADDRESS) begin
               d.sFixed = 1'b1;
            end else if (q.lsb == '0) begin
               d.sFixed = 1'b0;
            end
         end else if (cfgParam == PAR_MASK) begin
            d.sMask = cfgData;
         end else if (cfgParam == PAR_ROUTER) begin
            d.sRouter = cfgData;
         end
      end

      if (cfgRead) begin
         if (cfgProcess != CFG_PROCESS) begin
            d.cfgRd = NO_ADDRESS;
         end else if (cfgParam == PAR_HOST) begin
            d.cfgRd = q.sHost;
         end else if (cfgParam == PAR_MASK) begin
            d.cfgRd = q.sMask;
         end else if (cfgParam == PAR_ROUTER) begin
            d.cfgRd = q.sRouter;
         end else begin
            d.cfgRd = NO_ADDRESS;
         end
      end

      if (q.applyPend || (softRestart && q.sampled)) begin
         d.applyPend = 1'b0;
         d.aMask = q.sMask;
         d.aRouter = q.sRouter;
         if (q.mode == MODE_FIXED) begin
            d.src = SRC_FIXED;
            d.aHost = {DEFAULT_RANGE[IP_W-1:BYTE_W], q.lsb};
         end else if (q.mode == MODE_BOOTP) begin
            d.src = SRC_BOOTP;
            d.aHost = NO_ADDRESS;
         end else if (q.sFixed) begin
            d.src = SRC_FIXED;
            d.aHost = {q.sHost[IP_W-1:BYTE_W], (q.lsb != '0) ? q.lsb : q.sHost[BYTE_W-1:0]};
         end else begin
            d.src = SRC_DHCP;
            d.aHost = NO_ADDRESS;
         end
      end

      if (q.st != S_IDLE) begin
         d.lat = q.lat + 1'b1;
      end

      case (q.st)
         S_IDLE: begin
            d.lat = '0;
            if (reqValid && q.rdy) begin
               d.rdy = 1'b0;
               d.func = reqFunc;
               d.addr = reqAddr;
               d.cnt = reqCnt;
               d.val = reqValue;
               d.left = reqCnt;
               d.exc = EXC_NONE;
               d.st = S_RESP;
               if (reqFunc != FC_READ && reqFunc != FC_WRITE_ONE && reqFunc != FC_WRITE_MANY) begin
                  d.exc = EXC_FUNC;
               end else if (reqFunc == FC_READ && (reqCnt == '0 || reqCnt > MAX_READ)) begin
                  d.exc = EXC_VALUE;
               end else if (reqFunc == FC_WRITE_MANY && (reqCnt == '0 || reqCnt > MAX_WRITE)) begin
                  d.exc = EXC_VALUE;
               end else if (reqEnd > ADDR_SPAN) begin
                  d.exc = EXC_ADDR;
               end else begin
                  d.st = S_SCAN;
                  d.idx = (reqFunc == FC_READ) ? {1'b0, reqAddr} : reqEnd;
               end
            end
         end
         S_SCAN: begin
            // Writes only look past the end here; per-word checks come later
            if (q.idx == qEnd) begin
               if (aCont) begin
                  d.exc = EXC_ADDR;
                  d.st = S_RESP;
               end else if (q.func == FC_READ) begin
                  d.st = S_RESP;
               end else begin
                  d.st = S_WRITE;
                  d.idx = {1'b0, q.addr};
                  d.wrRdy = !single;
               end
            end else if (!aExists || (q.idx == {1'b0, q.addr} && aCont)) begin
               d.exc = EXC_ADDR;
               d.st = S_RESP;
            end else if (!aRead) begin
               d.exc = EXC_FAIL;
               d.st = S_RESP;
            end else begin
               d.idx = q.idx + 1'b1;
            end
         end
         S_WRITE: begin
            if (q.lat >= LAT_W'(RESP_CYC - RESP_GUARD)) begin
               // A stalled master must not hold the answer past the deadline
               if (q.exc == EXC_NONE) begin
                  d.exc = EXC_FAIL;
               end
               d.wrRdy = 1'b0;
               d.st = S_RESP;
            end else if (wordV) begin
               if (q.exc == EXC_NONE) begin
                  if (!aExists || (q.idx == {1'b0, q.addr} && aCont)) begin
                     d.exc = EXC_ADDR;
                  end else if (!aWrite) begin
                     d.exc = EXC_FAIL;
                  end else if (word > aLimit) begin
                     d.exc = EXC_FAIL;
                  end else begin
                     d.memWr = 1'b1;
                     d.memWa = q.idx[REG_AW-1:0];
                     d.memWd = word;
                  end
               end
               d.idx = q.idx + 1'b1;
               d.left = q.left - 1'b1;
               if (q.left == ONE_WORD) begin
                  d.wrRdy = 1'b0;
                  d.st = S_RESP;
               end
            end
         end
         S_RESP: begin
            d.respV = 1'b1;
            d.respF = (q.exc != EXC_NONE) ? (q.func | EXC_FLAG) : q.func;
            d.respE = q.exc;
            d.respA = q.addr;
            d.respQ = (q.func == FC_READ) ? (q.cnt << 1) : (single ? q.val : q.cnt);
            if (q.func == FC_READ && q.exc == EXC_NONE) begin
               d.st = S_STREAM;
               d.idx = {1'b0, q.addr};
               d.left = q.cnt;
            end else begin
               d.st = S_IDLE;
               d.rdy = 1'b1;
            end
         end
         S_STREAM: begin
            d.pend = 1'b1;
            d.pendLast = (q.left == ONE_WORD);
            d.idx = q.idx + 1'b1;
            d.left = q.left - 1'b1;
            if (q.left == ONE_WORD) begin
               d.st = S_IDLE;
               d.rdy = 1'b1;
            end
         end
         default: begin
            d.st = S_IDLE;
            d.rdy = 1'b1;
         end
      endcase

      if (q.pend) begin
         d.rdV = 1'b1;
         d.rdD = memRd;
         d.rdL = q.pendLast;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
         q.st <= S_IDLE;
         q.rdy <= 1'b1;
         q.sHost <= FACTORY_HOST;
         q.sFixed <= (FACTORY_HOST != NO_ADDRESS);
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reqReady = q.rdy;
   assign wrReady = q.wrRdy;
   assign respValid = q.respV;
   assign respFunc = q.respF;
   assign respExc = q.respE;
   assign respAddr = q.respA;
   assign respQty = q.respQ;
   assign rdValid = q.rdV;
   assign rdData = q.rdD;
   assign rdLast = q.rdL;
   assign cfgRdData = q.cfgRd;
   assign networkHostAddress = q.aHost;
   assign networkMaskSetting = q.aMask;
   assign networkRouterAddress = q.aRouter;
   assign addrSource = q.src;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence reqTaken;
      reqValid && reqReady;
   endsequence

   sequence applyNow;
      q.applyPend;
   endsequence

   rd_count_a: assert property (reqTaken ##0 (reqFunc == FC_READ && (reqCount == '0 || reqCount > MAX_READ))
      |-> ##2 respValid && respExc == EXC_VALUE) else $error("bad read count not refused");
   wr_count_a: assert property (reqTaken ##0 (reqFunc == FC_WRITE_MANY && (reqCount == '0 || reqCount > MAX_WRITE))
      |-> ##2 respValid && respExc == EXC_VALUE) else $error("bad write count not refused");
   exc_format_a: assert property (reqTaken ##0 (reqFunc != FC_READ && reqFunc != FC_WRITE_ONE && reqFunc != FC_WRITE_MANY)
      |-> ##2 respValid && respExc == EXC_FUNC && respFunc == ($past(reqFunc, 2) | EXC_FLAG))
      else $error("exception answer malformed");
   resp_deadline_a: assert property (q.lat < LAT_W'(RESP_CYC)) else $error("answer deadline passed");
   switch_hold_a: assert property (q.sampled |=> $stable(q.mode) && $stable(q.lsb))
      else $error("switches resampled");
   fixed_addr_a: assert property (applyNow ##0 (q.mode == MODE_FIXED)
      |=> addrSource == SRC_FIXED && networkHostAddress == {DEFAULT_RANGE[IP_W-1:BYTE_W], $past(q.lsb)})
      else $error("fixed address wrong");
   bootp_mode_a: assert property (applyNow ##0 (q.mode == MODE_BOOTP) |=> addrSource == SRC_BOOTP)
      else $error("boot protocol not selected");
   dhcp_mode_a: assert property (applyNow ##0 (q.mode == MODE_SOFTWARE_CONFIG && !q.sFixed)
      |=> addrSource == SRC_DHCP && networkHostAddress == NO_ADDRESS) else $error("dynamic mode not selected");
   restore_erase_a: assert property (!q.sampled && modeSwitch == MODE_RESTORE
      |=> q.sHost == NO_ADDRESS && !q.sFixed) else $error("restore did not erase");
   cfg_fixed_a: assert property (q.sampled && cfgWrite && cfgProcess == CFG_PROCESS && cfgParam == PAR_HOST
      && cfgData != NO_ADDRESS |=> q.sFixed && q.sHost == $past(cfgData)) else $error("host write not fixed");
   deferred_apply_a: assert property (cfgWrite && !softRestart && !q.applyPend && q.sampled
      |=> $stable(networkHostAddress)) else $error("setting applied early");
   discard_rest_a: assert property (q.st == S_WRITE && q.exc != EXC_NONE |=> !q.memWr)
      else $error("value kept after exception");
endmodule

// ### verification/modbus_master_model.sv
// Master stand-in: sends one request, feeds write words with stalls.
// Assumes the slave takes a request on an edge with reqValid and reqReady.
module modbus_master_model
   import mbs_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Request
   output logic reqValid = 1'b0,
   output logic [7:0] reqFunc = 8'h00,
   output logic [15:0] reqAddr = 16'h0000,
   output logic [15:0] reqCount = 16'h0000,
   output logic [15:0] reqValue = 16'h0000,
   input wire logic reqReady,
   // Write words
   output logic wrValid = 1'b0,
   output logic [15:0] wrData = 16'h0000,
   input wire logic wrReady,
   // Answer
   input wire logic respValid,
   input wire logic [7:0] respFunc,
   input wire logic [7:0] respExc,
   input wire logic rdValid,
   input wire logic [15:0] rdData
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Capture
   // ****
   logic [7:0] gotFunc;
   logic [7:0] gotExc;
   logic gotResp = 1'b0;
   logic [15:0] rdWords[$];
   int waited;
   always @(negedge core_clk) begin
      if (respValid === 1'b1) begin
         gotFunc = respFunc;
         gotExc = respExc;
         gotResp = 1'b1;
      end
      if (rdValid === 1'b1) rdWords.push_back(rdData);
   end
   // Called just after an edge; a word is held until the slave takes it
   task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
                       input logic [15:0] v, input int limit);
      int k;
      logic rdy;
      k = 0;
      gotResp = 1'b0;
      rdWords.delete();
      waited = 0;
      reqValid = 1'b1;
      reqFunc = f;
      reqAddr = a;
      reqCount = c;
      reqValue = v;
      while (reqReady !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      #1;
      reqValid = 1'b0;
      reqAddr = ~a;
      reqCount = ~c;
      reqValue = ~v;
      while (!gotResp && waited < limit) begin
         rdy = wrReady;
         if (!wrValid) wrValid = f == FC_WRITE_MANY && k < c && waited[0];
         wrData = 16'h0010 + k[15:0];
         @(posedge core_clk);
         #1;
         if (wrValid && rdy) begin
            k++;
            wrValid = 1'b0;
         end
         waited++;
      end
      wrValid = 1'b0;
      wrData = ~wrData;
      repeat (8) @(posedge core_clk);
      #1;
   endtask
endmodule

// ### verification/tb_modbus_slave_netconfig.sv
// Self-checking bench for the slave front end and address source logic.
// Assumes the master model file and the design package are compiled first.
module tb_modbus_slave_netconfig
   import mbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Bench
   // ****
   localparam int RESP = 64;
   logic core_clk = 0, sys_rst = 1, softRestart = 0, cfgWrite = 0, cfgRead = 0;
   logic [3:0] modeSwitch = 0;
   logic [7:0] lowByteSwitch = 0, cfgProcess = 0, cfgParam = 0;
   logic [31:0] cfgData = 0;
   logic reqValid, reqReady, wrValid, wrReady, respValid, rdValid, rdLast;
   logic [7:0] reqFunc, respFunc, respExc;
   logic [15:0] reqAddr, reqCount, reqValue, wrData, respAddr, respQty, rdData;
   logic [31:0] cfgRdData, networkHostAddress, networkMaskSetting, networkRouterAddress;
   logic [1:0] addrSource;
   int mismatches = 0, cmp_count = 0, seed = 32'he872, a, c;
   always #20 core_clk = ~core_clk;
   modbus_slave_netconfig #(.RESP_CYC(RESP)) modbus_slave_netconfig_i (.core_clk, .sys_rst, .reqValid,
      .reqFunc, .reqAddr, .reqCount, .reqValue, .reqReady, .wrValid, .wrData, .wrReady, .respValid,
      .respFunc, .respExc, .respAddr, .respQty, .rdValid, .rdData, .rdLast, .modeSwitch, .lowByteSwitch,
      .softRestart, .cfgWrite, .cfgRead, .cfgProcess, .cfgParam, .cfgData, .cfgRdData,
      .networkHostAddress, .networkMaskSetting, .networkRouterAddress, .addrSource);
   modbus_master_model m (.core_clk, .reqValid, .reqFunc, .reqAddr, .reqCount, .reqValue, .reqReady,
      .wrValid, .wrData, .wrReady, .respValid, .respFunc, .respExc, .rdValid, .rdData);
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [7:0] e);
      m.send(f, a, c, 16'h0100 << (a % 2), 2 * RESP);
      ck(m.gotFunc, e != 0 ? f | EXC_FLAG : f);
      ck(m.gotExc, e);
      ck(32'(m.waited <= RESP), 32'h1);
   endtask
   task automatic power(input logic [3:0] md, input logic [7:0] b);
      sys_rst = 1;
      modeSwitch = md;
      lowByteSwitch = b;
      repeat (16) @(posedge core_clk);
      #1 sys_rst = 0;
      repeat (3) @(posedge core_clk);
      // Switch moves after power-up must not matter
      #1 modeSwitch = md ^ 4'h2;
      lowByteSwitch = ~b;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic cfg(input logic [7:0] p, input logic [31:0] d);
      cfgWrite = 1;
      cfgProcess = CFG_PROCESS;
      cfgParam = p;
      cfgData = d;
      @(posedge core_clk);
      #1 cfgWrite = 0;
      cfgRead = 1;
      @(posedge core_clk);
      #1 cfgRead = 0;
      @(posedge core_clk);
      #1 ck(cfgRdData, d);
   endtask
   task automatic restart;
      softRestart = 1;
      @(posedge core_clk);
      #1 softRestart = 0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   function automatic logic [7:0] expRd(input int a, input int c);
      if (a + c > REG_DEPTH || a == 7 || a + c == 7) return EXC_ADDR;
      return a == 0 ? EXC_FAIL : EXC_NONE;
   endfunction
   task automatic results;
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      results();
   end
   initial begin
      for (int md = 0; md < 4; md++) begin
         power(md[3:0], 8'h37);
         ck(addrSource, md == 1 ? SRC_BOOTP : md == 2 ? SRC_FIXED : SRC_DHCP);
         if (md != 1) ck(networkHostAddress, md == 2 ? {DEFAULT_RANGE[31:8], 8'h37} : NO_ADDRESS);
      end
      power(MODE_SOFTWARE_CONFIG, 8'h00);
      cfg(PAR_HOST, 32'h0a000005);
      cfg(PAR_MASK, 32'hffffff00);
      ck(addrSource, SRC_DHCP);
      restart();
      ck(addrSource, SRC_FIXED);
      ck(networkHostAddress, 32'h0a000005);
      ck(networkMaskSetting, 32'hffffff00);
      cfg(PAR_HOST, NO_ADDRESS);
      restart();
      ck(addrSource, SRC_DHCP);
      power(MODE_SOFTWARE_CONFIG, 8'h21);
      cfg(PAR_ROUTER, 32'h0a000001);
      cfg(PAR_HOST, 32'h0a000005);
      restart();
      ck(networkHostAddress, 32'h0a000021);
      ck(networkRouterAddress, 32'h0a000001);
      cfg(PAR_HOST, NO_ADDRESS);
      restart();
      ck(addrSource, SRC_FIXED);
      power(MODE_RESTORE, 8'h00);
      power(MODE_SOFTWARE_CONFIG, 8'h00);
      ck(networkRouterAddress, NO_ADDRESS);
      req(FC_READ, 1, 2, EXC_NONE);
      req(FC_READ, 1, 0, EXC_VALUE);
      req(FC_READ, 1, 126, EXC_VALUE);
      req(FC_READ, 1, 125, EXC_ADDR);
      req(FC_READ, 0, 1, EXC_FAIL);
      req(FC_READ, 15, 2, EXC_ADDR);
      req(8'h05, 0, 1, EXC_FUNC);
      req(FC_WRITE_ONE, 4, 1, EXC_FAIL);
      req(FC_WRITE_ONE, 1, 1, EXC_FAIL);
      req(FC_WRITE_ONE, 7, 1, EXC_ADDR);
      req(FC_WRITE_ONE, 16, 1, EXC_ADDR);
      req(FC_WRITE_MANY, 8, 124, EXC_VALUE);
      req(FC_WRITE_MANY, 8, 0, EXC_VALUE);
      req(FC_WRITE_MANY, 8, 2, EXC_NONE);
      req(FC_READ, 8, 2, EXC_NONE);
      ck({respAddr, respQty}, 32'h00080004);
      ck({m.rdWords[0], m.rdWords[1]}, 32'h00100011);
      req(FC_WRITE_MANY, 3, 3, EXC_FAIL);
      req(FC_READ, 3, 1, EXC_NONE);
      ck(m.rdWords[0], 32'h10);
      req(FC_READ, 5, 1, EXC_NONE);
      ck(m.rdWords[0], 32'h0);
      repeat (20) begin
         a = {$random(seed)} % 15 + 1;
         c = {$random(seed)} % 4 + 1;
         req(FC_READ, a[15:0], c[15:0], expRd(a, c));
      end
      results();
   end
endmodule
